// *** shared/page_check_pkg.sv ***
/*
 Constants, field positions and types for the page descriptor access check.
 Assumes the checking logic runs on a single clock with a synchronous reset.
*/
// How it works
// [R01] Any abort raised by the checks points control at kernel vector 250.
// [R02] A vector fetch that is itself invalid aborts again like any access.
// [R03] Kernel software keeps virtual 250 mapped, else aborts loop forever.
// [R04] A descriptor with bit 15 set sends the reference past the cache.
// [R05] A bypassed reference that hits the cache invalidates that location.
// [R06] Bits 14:08 hold the page length, compared on every relocation.
// [R07] Upward pages fault above the length, downward pages fault below it.
// [R08] Any write into a page sets its written flag at bit 06; the code sets it only for writes that raise no abort.
// [R09] Writing a page's base or descriptor register clears its flag.
// [R10] Bit 03 picks growth: 0 grows up from block 0, 1 down from 127.
// [R11] Access code 00 and 10 abort all, 01 aborts writes, 11 allows all.
// [R12] The top three address bits pick the base and descriptor pair.
// [R13] The block number is the seven bits just above the displacement.
// [R14] Descriptor bits 07, 05, 04 and 00 read as zero and ignore writes.
package page_check_pkg;
   localparam int          PAGE_COUNT   = 8;
   localparam int          SET_COUNT    = 6;
   localparam int          SEL_W        = 3;
   localparam int          SET_W        = 3;
   localparam int          DESC_W       = 16;
   localparam int          VADDR_W      = 16;
   localparam int          BYPASS_BIT   = 15;
   localparam int          LEN_HI       = 14;
   localparam int          LEN_LO       = 8;
   localparam int          WRITTEN_BIT  = 6;
   localparam int          DIR_BIT      = 3;
   localparam int          ACC_HI       = 2;
   localparam int          ACC_LO       = 1;
   localparam int          BLK_HI       = 12;
   localparam int          BLK_LO       = 6;
   localparam int          PAGE_HI      = 15;
   localparam int          PAGE_LO      = 13;
   localparam logic [15:0] WRITABLE_MASK = 16'hff0e;
   localparam logic [15:0] DESC_RESET   = 16'h0000;
   localparam logic [15:0] ABORT_VECTOR = 16'h00a8;
   typedef enum logic [1:0] {
      ACC_NONRES = 2'h0,
      ACC_RDONLY = 2'h1,
      ACC_UNUSED = 2'h2,
      ACC_RDWR   = 2'h3
   } access_e;
endpackage : page_check_pkg

// *** rtl/page_descriptor_access_check.sv ***
/*
 Descriptor storage and per-reference access check for the relocation unit.
 Assumes the CPU presents one reference per cycle with mode and space already
 folded into a set index, and that software writes arrive on separate strobes.
 The file also holds the purely combinational per-reference checker.
*/
`timescale 1ns/1ps
module page_descriptor_access_check #(
   parameter int SETS = page_check_pkg::SET_COUNT
) (
   // Clock and reset.
   input  wire logic                              clock,
   input  wire logic                              sys_rst,
   // Reference from the translation path.
   input  wire logic                              refValid,
   input  wire logic                              refWrite,
   input  wire logic                              refIllegalMode,
   input  wire logic [page_check_pkg::SET_W-1:0]  refSet,
   input  wire logic [page_check_pkg::VADDR_W-1:0] refVaddr,
   input  wire logic                              cacheHit,
   // Software access to descriptors and base registers.
   input  wire logic                              descWrite,
   input  wire logic                              baseWrite,
   input  wire logic [page_check_pkg::SET_W-1:0]  regSet,
   input  wire logic [page_check_pkg::SEL_W-1:0]  regPage,
   input  wire logic [page_check_pkg::DESC_W-1:0] regWdata,
   output logic      [page_check_pkg::DESC_W-1:0] descRdata,
   // Check results.
   output logic                                   abortValid,
   output logic                                   abortNonres,
   output logic                                   abortLength,
   output logic                                   abortRdonly,
   output logic      [page_check_pkg::VADDR_W-1:0] abortVector,
   output logic                                   cacheBypass,
   output logic                                   cacheInvalidate
);
   import page_check_pkg::*;

   localparam int ENTRIES = SETS * PAGE_COUNT;

   // Stored descriptors, the readback word and the one-cycle result pulses.
   typedef struct packed {
      logic [ENTRIES-1:0][DESC_W-1:0] desc;
      logic [DESC_W-1:0]              rdata;
      logic                           abortV;
      logic                           nonres;
      logic                           length;
      logic                           rdonly;
      logic                           bypass;
      logic                           inval;
   } state_s;

   state_s            st_r;
   state_s            st_nxt;
   logic              refMapped;
   int                refIdx;
   logic [DESC_W-1:0] refDesc;
   logic              nonErr;
   logic              lenErr;
   logic              roErr;

   // Pair selection. A set index beyond the implemented sets selects no
   // pair and reads as the reset descriptor, which is nonresident.
   always_comb begin
      refMapped = int'(refSet) < SETS;
      refIdx    = 0;
      refDesc   = DESC_RESET;
      if (refMapped) begin
         refIdx = int'(refSet) * PAGE_COUNT +
                  int'(refVaddr[PAGE_HI:PAGE_LO]); // [R12]
      end
      for (int i = 0; i < ENTRIES; i++) begin
         if (refMapped && i == refIdx) begin
            refDesc = st_r.desc[i];
         end
      end
   end

   // Every reference is checked the same way, vector fetches included.
   page_ref_check u_page_ref_check (
      .desc        (refDesc),
      .vaddr       (refVaddr),
      .write       (refWrite),
      .illegalMode (refIllegalMode),
      .nonErr      (nonErr),
      .lenErr      (lenErr),
      .roErr       (roErr)
   ); // [R02]

   always_comb begin
      int   regIdx;
      logic regMapped;
      logic anyErr;
      logic setW;
      regIdx    = 0;
      // Register accesses to an unimplemented set are dropped, read as zero.
      regMapped = int'(regSet) < SETS;
      anyErr    = nonErr || lenErr || roErr;
      // Only a write that passes every check marks its page.
      setW      = refValid && refWrite && refMapped && !anyErr; // [R08]
      st_nxt    = st_r;
      if (regMapped) begin
         regIdx = int'(regSet) * PAGE_COUNT + int'(regPage);
      end

      // Results are registered, so each pulse stands the cycle after.
      st_nxt.abortV = refValid && anyErr; // [R01]
      st_nxt.nonres = refValid && nonErr; // [R11]
      st_nxt.length = refValid && lenErr; // [R07]
      st_nxt.rdonly = refValid && roErr; // [R11]
      st_nxt.bypass = refValid && refDesc[BYPASS_BIT]; // [R04]
      st_nxt.inval  = refValid && refDesc[BYPASS_BIT] && cacheHit; // [R05]

      // The set comes after the clear, so a same-cycle write wins.
      for (int i = 0; i < ENTRIES; i++) begin
         if (regMapped && i == regIdx) begin
            if (descWrite) begin
               st_nxt.desc[i] = regWdata & WRITABLE_MASK; // [R14] [R09]
            end else if (baseWrite) begin
               st_nxt.desc[i][WRITTEN_BIT] = 1'b0; // [R09]
            end
         end
         if (setW && i == refIdx) begin
            st_nxt.desc[i][WRITTEN_BIT] = 1'b1; // [R08]
         end
      end

      // Read back the selected descriptor as it stands after this cycle.
      st_nxt.rdata = DESC_RESET;
      for (int i = 0; i < ENTRIES; i++) begin
         if (regMapped && i == regIdx) begin
            st_nxt.rdata = st_nxt.desc[i];
         end
      end
   end

   // Descriptors come up nonresident, so nothing maps until software loads.
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         st_r      <= '0;
         st_r.desc <= {ENTRIES{DESC_RESET}};
      end else begin
         st_r <= st_nxt;
      end
   end

   // The vector is a fixed kernel location; software must keep it mapped,
   // or a failing vector fetch aborts again and again.
   assign descRdata       = st_r.rdata;
   assign abortValid      = st_r.abortV;
   assign abortNonres     = st_r.nonres;
   assign abortLength     = st_r.length;
   assign abortRdonly     = st_r.rdonly;
   assign abortVector     = ABORT_VECTOR; // [R01]
   assign cacheBypass     = st_r.bypass;
   assign cacheInvalidate = st_r.inval;
endmodule : page_descriptor_access_check

// Checks one reference against its descriptor and reports each abort cause.
// It holds no state; the storage module registers its results.
module page_ref_check (
   // Descriptor selected for the reference.
   input  wire logic [page_check_pkg::DESC_W-1:0]  desc,
   // Reference attributes.
   input  wire logic [page_check_pkg::VADDR_W-1:0] vaddr,
   input  wire logic                               write,
   input  wire logic                               illegalMode,
   // Abort causes found.
   output logic                                    nonErr,
   output logic                                    lenErr,
   output logic                                    roErr
);
   import page_check_pkg::*;

   localparam int BLK_W = BLK_HI - BLK_LO + 1;

   always_comb begin
      logic [BLK_W-1:0] blk;
      logic [BLK_W-1:0] lim;
      access_e          acc;
      blk    = vaddr[BLK_HI:BLK_LO]; // [R13]
      lim    = desc[LEN_HI:LEN_LO]; // [R06]
      acc    = access_e'(desc[ACC_HI:ACC_LO]);
      nonErr = 1'b0;
      lenErr = 1'b0;
      roErr  = 1'b0;

      // Upward pages end at the length block, downward pages start there.
      if (desc[DIR_BIT]) begin // [R10]
         lenErr = blk < lim; // [R07]
      end else begin
         lenErr = blk > lim; // [R07]
      end

      // Codes 00 and 10 abort every access; 01 aborts writes only.
      case (acc)
         ACC_NONRES: begin
            nonErr = 1'b1; // [R11]
         end
         ACC_RDONLY: begin
            roErr = write; // [R11]
         end
         ACC_UNUSED: begin
            nonErr = 1'b1; // [R11]
         end
         ACC_RDWR: begin
            nonErr = 1'b0; // [R11]
         end
      endcase

      // Illegal mode reports only the nonresident cause.
      if (illegalMode) begin
         nonErr = 1'b1;
         lenErr = 1'b0;
         roErr  = 1'b0;
      end
   end
endmodule : page_ref_check

// *** test/page_descriptor_access_check_monitor.sv ***
/* Port checker. Assumes the design's port names. */
`timescale 1ns/1ps
module page_descriptor_access_check_monitor #(parameter int SETS = 6) (
   input wire logic clock, sys_rst, refValid, refWrite, refIllegalMode,
   input wire logic cacheHit, descWrite, baseWrite,
   input wire logic [2:0] refSet, regSet, regPage,
   input wire logic [15:0] refVaddr, regWdata, descRdata, abortVector,
   input wire logic abortValid, abortNonres, abortLength, abortRdonly,
   input wire logic cacheBypass, cacheInvalidate
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   a_vector_fixed: assert property (abortVector == 16'h00a8)
      else $error("vector moved");
   a_illegal_aborts: assert property (refValid && refIllegalMode |=>
      abortValid && abortNonres) else $error("no abort");
   a_idle_quiet: assert property (!refValid |=>
      !abortValid && !cacheBypass) else $error("stray pulse");
   a_abort_cause: assert property (abortValid ==
      (abortNonres || abortLength || abortRdonly)) else $error("no cause");
   a_inval_hit: assert property (cacheInvalidate |->
      cacheBypass && $past(cacheHit)) else $error("bad invalidate");
   a_ro_write: assert property (abortRdonly |->
      $past(refWrite) && !$past(refIllegalMode)) else $error("bad ro");
   a_unused_zero: assert property ((descRdata & 16'h00b1) == 16'h0000)
      else $error("unused bit set");
   a_length_ref: assert property (abortLength |-> $past(refValid))
      else $error("bad length");
   a_wbit_clear: assert property (
      ($past(descWrite) || $past(baseWrite)) &&
      !($past(refValid) && $past(refWrite)) |-> !descRdata[6])
      else $error("written flag not cleared");
   a_desc_masked: assert property (
      $past(descWrite) && $past(regSet) < SETS |->
      (descRdata & 16'hff0e) == ($past(regWdata) & 16'hff0e))
      else $error("descriptor write lost");
endmodule : page_descriptor_access_check_monitor
bind page_descriptor_access_check page_descriptor_access_check_monitor
   #(.SETS(SETS)) u_mon (.*);

// *** test/cpu_ref_model.sv ***
/* Translation path model. Assumes calls from the bench. */
`timescale 1ns/1ps
module cpu_ref_model (
   input wire logic clock,
   output logic refValid, refWrite, refIllegalMode, cacheHit,
   output logic [2:0] refSet,
   output logic [15:0] refVaddr
);
   initial {refValid, refWrite, refIllegalMode, cacheHit} = 4'h0;
   initial {refSet, refVaddr} = 19'h0_0000;
   // Aborts are never retried here, so no vector loop can form.
   task automatic issue(input logic [21:0] r);
      @(posedge clock) #1;
      {refIllegalMode, refWrite, cacheHit, refSet, refVaddr} = r;
      refValid = 1;
      @(posedge clock) #1;
      {refValid, refWrite, cacheHit} = {1'b0, ~refWrite, ~cacheHit};
      refVaddr = ~refVaddr;
   endtask : issue
endmodule : cpu_ref_model

// *** test/page_descriptor_access_check_tb.sv ***
/* Random bench against a model. Assumes the package. */
`timescale 1ns/1ps
module page_descriptor_access_check_tb;
   import page_check_pkg::*;
   logic clock = 0, sys_rst = 1, descWrite = 0, baseWrite = 0;
   logic refValid, refWrite, refIllegalMode, cacheHit, abortValid;
   logic abortNonres, abortLength, abortRdonly, cacheBypass, cacheInvalidate;
   logic [2:0] refSet, regSet = 0, regPage = 0;
   logic [15:0] refVaddr, regWdata = 0, descRdata, abortVector, d;
   logic [31:0] seed = 19253;
   logic [21:0] r;
   logic w, nr, le, ro;
   int nFail = 0, totalChecks = 0, cycles = 0;
   always #4 clock = ~clock;
   page_descriptor_access_check u_page_descriptor_access_check (.*);
   cpu_ref_model u_cpu_ref_model (.*);
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   task chk(string nm, logic [15:0] e, logic [15:0] s);
      totalChecks++;
      if (s !== e) begin
         nFail++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, s);
      end
   endtask : chk
   task results();
      $display("checks %0d fails %0d", totalChecks, nFail);
      if (nFail == 0 && totalChecks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results
   always @(posedge clock) if (++cycles == 5000) begin
      nFail++;
      results();
   end
   initial begin
      repeat (5) @(posedge clock);
      #1 sys_rst = 0;
      @(posedge clock) #1 chk("reset", 16'h0000, descRdata);
      repeat (200) begin
         d = 16'(rnd());
         r = 22'(rnd());
         r[21] = (rnd() % 8) == 0;
         r[18:16] = r[18:16] % 6;
         {regSet, regPage, regWdata, descWrite} = {r[18:13], d, 1'b1};
         @(posedge clock) #1 descWrite = 0;
         u_cpu_ref_model.issue(r);
         nr = r[21] || !d[1];
         le = !r[21] && (d[3] ? r[12:6] < d[14:8] : r[12:6] > d[14:8]);
         ro = !r[21] && d[2:1] == 2'h1 && r[20];
         w = r[20] && !(nr || le || ro);
         chk("abortValid", 16'(nr || le || ro), abortValid);
         chk("abortNonres", 16'(nr), abortNonres);
         chk("abortLength", 16'(le), abortLength);
         chk("abortRdonly", 16'(ro), abortRdonly);
         chk("cacheBypass", 16'(d[15]), cacheBypass);
         chk("cacheInvalidate", 16'(d[15] && r[19]), cacheInvalidate);
         chk("abortVector", 16'h00a8, abortVector);
         baseWrite = 1'(rnd() % 2);
         w = w && !baseWrite;
         @(posedge clock) #1 baseWrite = 0;
         chk("descRdata", (d & WRITABLE_MASK) | {9'h0, w, 6'h0}, descRdata);
      end
      $display("test random done");
      results();
   end
endmodule : page_descriptor_access_check_tb
